//--- common/pce_pkg.sv
// Package: constants and types for the pump channel enable and status block
package pce_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CHSTAT = 8'h04;
  localparam logic [7:0] OFF_IRQST  = 8'h08;
  localparam logic [7:0] OFF_IRQMSK = 8'h0C;
  localparam logic [7:0] OFF_SYS    = 8'h10;
  localparam logic [7:0] OFF_RATE   = 8'h14;
  localparam logic [7:0] OFF_VOLUME = 8'h18;
  localparam logic [7:0] OFF_LAMPS  = 8'h1C;

  // CTRL: enable/disable are write-one pulses, ready bits are stored; bits per channel
  localparam int CTRL_EN_REQ  = 0;
  localparam int CTRL_DIS_REQ = 2;
  localparam int CTRL_READY   = 4;

  // IRQ status bits
  localparam int IRQ_LOCKWARN = 0;
  localparam int IRQ_FAULT    = 2;
  localparam int IRQ_TOGGLE   = 4;
  localparam int IRQ_W        = 6;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [NUM_CH-1:0] RST_ENABLE = 2'h0;
  localparam logic [IRQ_W-1:0]  RST_MASK   = 6'h00;
  localparam int CLK_HZ        = 50_000_000;
  localparam int DEBOUNCE_US   = 10_000;
  localparam int DEBOUNCE_CYC  = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int DB_W          = 20;
  localparam int ACT_HOLD_CYC  = 2_500_000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCE_SW_REMOTE = 2'h0,
    PCE_SW_SELECT = 2'h1,
    PCE_SW_LOCK   = 2'h2
  } pce_sw_t;

  typedef struct packed {
    logic running;
    logic load_need;
    logic loading;
    logic lin_fault;
    logic rot_fault;
  } pce_ch_in_t;

  typedef struct packed {
    logic green_en;
    logic red_dis;
    logic green_act;
    logic red_idle;
    logic yel_load;
    logic red_fault;
  } pce_lamp_t;

  typedef struct packed {
    logic rx_data;
    logic tx_data;
    logic rx_ctl;
    logic tx_ctl;
  } pce_ser_t;

  typedef struct packed {
    logic ready;
    logic fault_n;
    logic load_ok;
  } pce_plc_t;

endpackage

//--- rtl/pce_debounce.sv
// Debounce filter that turns a noisy momentary input into one press pulse
`timescale 1ns/1ps
`default_nettype none
module pce_debounce
  import pce_pkg::*;
#(
  parameter int unsigned COUNT = DEBOUNCE_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw,
  output logic      press
);

  logic [DB_W-1:0] cnt;
  logic            stable;

  // ----------------------------------------------------------------
  // Filter: level must hold COUNT cycles before it is accepted
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= '0;
      stable <= 1'b0;
    end else if (raw == stable) begin
      cnt <= '0;
    end else if (cnt >= DB_W'(COUNT - 1)) begin
      cnt    <= '0;
      stable <= raw;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // One pulse on the accepted rising edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press <= 1'b0;
    end else begin
      press <= (raw != stable) && raw && (cnt >= DB_W'(COUNT - 1));
    end
  end

endmodule
`default_nettype wire

//--- rtl/pce_top.sv
// Top: channel enable control, status lamps, PLC outputs, APB registers
// ----------------------------------------------------------------
// Functional notes
// - Centre switch position lets host enable/disable
// - Upper momentary press toggles enable state
// - Lower position forces disable, refuses host enable
// - Host enable under lockout raises warning
// - Green lamp enabled, red lamp disabled
// - Green lamp running, red lamp idle
// - Yellow lamp when load needed or loading
// - Fault lamp on linear or rotary fault
// - Serial rx/tx data and control lamps
// - Volumes microsteps, rates microsteps per second
// - Channel strokes alternate for continuous flow
// - PLC trigger in; ready, fault, load out
// - System fault output true when none faulted
// - System ready only when all channels ready
// - Load output conducts when no enabled load
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pce_top
  import pce_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
  parameter int unsigned ACT_HOLD = ACT_HOLD_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire pce_sw_t                sw_pos  [NUM_CH],
  input  wire pce_ch_in_t             ch_in   [NUM_CH],
  input  wire logic                   ser_rx,
  input  wire logic                   ser_tx,
  input  wire logic                   ser_rx_ctl,
  input  wire logic                   ser_tx_ctl,
  input  wire logic                   plc_trigger,
  input  wire logic [NUM_CH-1:0]      stroke_done,
  output pce_lamp_t                   lamp    [NUM_CH],
  output pce_ser_t                    ser_lamp,
  output pce_plc_t                    plc_out,
  output logic      [NUM_CH-1:0]      ch_run,
  output logic      [NUM_CH-1:0]      ch_enable,
  output logic      [31:0]            rate_usps,
  output logic      [31:0]            volume_ustep,
  output logic                        irq
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic wr_acc;
  logic rd_setup;
  logic mapped;

  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped  = (paddr == OFF_CTRL) || (paddr == OFF_CHSTAT) || (paddr == OFF_IRQST) ||
                   (paddr == OFF_IRQMSK) || (paddr == OFF_SYS) || (paddr == OFF_RATE) ||
                   (paddr == OFF_VOLUME) || (paddr == OFF_LAMPS);
  assign pslverr = psel && penable && !mapped;

  logic [NUM_CH-1:0] host_en;
  logic [NUM_CH-1:0] host_dis;
  logic [NUM_CH-1:0] host_ready;
  logic [NUM_CH-1:0] press;
  logic [NUM_CH-1:0] lock_warn;
  logic [NUM_CH-1:0] fault;
  logic [NUM_CH-1:0] need_load;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_evt;
  logic [NUM_CH-1:0] fault_q;
  logic              alt_sel;
  logic              trig_q;

  assign host_en  = (wr_acc && paddr == OFF_CTRL) ? pwdata[CTRL_EN_REQ +: NUM_CH]  : '0;
  assign host_dis = (wr_acc && paddr == OFF_CTRL) ? pwdata[CTRL_DIS_REQ +: NUM_CH] : '0;

  // ----------------------------------------------------------------
  // Per-channel enable control and lamps
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      pce_debounce #(
        .COUNT (DEBOUNCE)
      ) u_db (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (sw_pos[g] == PCE_SW_SELECT),
        .press   (press[g])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_enable[g] <= RST_ENABLE[g];
        end else if (sw_pos[g] == PCE_SW_LOCK) begin
          ch_enable[g] <= 1'b0;
        end else if (press[g]) begin
          ch_enable[g] <= !ch_enable[g];
        end else if (host_dis[g]) begin
          ch_enable[g] <= 1'b0;
        end else if (host_en[g]) begin
          ch_enable[g] <= 1'b1;
        end
      end

      // Refused host enable under lockout is reported as a warning event
      assign lock_warn[g] = host_en[g] && (sw_pos[g] == PCE_SW_LOCK);
      assign fault[g]     = ch_in[g].lin_fault || ch_in[g].rot_fault;
      assign need_load[g] = ch_in[g].load_need || ch_in[g].loading;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lamp[g] <= '0;
        end else begin
          lamp[g].green_en  <= ch_enable[g];
          lamp[g].red_dis   <= !ch_enable[g];
          lamp[g].green_act <= ch_in[g].running;
          lamp[g].red_idle  <= !ch_in[g].running;
          lamp[g].yel_load  <= need_load[g];
          lamp[g].red_fault <= fault[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Serial activity lamps, stretched so short bursts stay visible
  // ----------------------------------------------------------------
  logic [3:0]  ser_raw;
  logic [31:0] act_cnt [4];
  assign ser_raw = {ser_rx, ser_tx, ser_rx_ctl, ser_tx_ctl};

  generate
    for (g = 0; g < 4; g++) begin : gen_act
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          act_cnt[g] <= '0;
        end else if (ser_raw[g]) begin
          act_cnt[g] <= 32'(ACT_HOLD);
        end else if (act_cnt[g] != '0) begin
          act_cnt[g] <= act_cnt[g] - 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_lamp <= '0;
    end else begin
      ser_lamp.rx_data <= act_cnt[3] != '0;
      ser_lamp.tx_data <= act_cnt[2] != '0;
      ser_lamp.rx_ctl  <= act_cnt[1] != '0;
      ser_lamp.tx_ctl  <= act_cnt[0] != '0;
    end
  end

  // ----------------------------------------------------------------
  // Alternating stroke sequencing of the two channels
  // ----------------------------------------------------------------
  // One channel runs at a time; a finished stroke hands over to the other
  // only if that one is enabled, fault-free and not in need of a load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_sel <= 1'b0;
    end else if (stroke_done[alt_sel] && ch_enable[!alt_sel] && !fault[!alt_sel] &&
                 !need_load[!alt_sel]) begin
      alt_sel <= !alt_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 1'b0;
      ch_run <= '0;
    end else begin
      trig_q <= plc_trigger;
      for (int i = 0; i < NUM_CH; i++) begin
        ch_run[i] <= trig_q && (alt_sel == 1'(i)) && ch_enable[i] && !fault[i] && !need_load[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // PLC outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plc_out <= '0;
    end else begin
      plc_out.ready   <= &host_ready;
      plc_out.fault_n <= !(|fault);
      plc_out.load_ok <= !(|(need_load & ch_enable));
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Rate and volume are stored raw in microsteps; no unit conversion here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ready   <= '0;
      irq_mask     <= RST_MASK;
      rate_usps    <= '0;
      volume_ustep <= '0;
    end else if (wr_acc) begin
      if (paddr == OFF_CTRL) begin
        host_ready <= pwdata[CTRL_READY +: NUM_CH];
      end
      if (paddr == OFF_IRQMSK) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
      if (paddr == OFF_RATE) begin
        rate_usps <= pwdata;
      end
      if (paddr == OFF_VOLUME) begin
        volume_ustep <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= '0;
    end else begin
      fault_q <= fault;
    end
  end

  assign irq_evt = {press, fault & ~fault_q, lock_warn};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      if (wr_acc && paddr == OFF_IRQST) begin
        irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  logic [31:0] lamp_word;

  always_comb begin
    lamp_word = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      lamp_word[i*6 +: 6] = lamp[i];
    end
    lamp_word[12 +: 4] = ser_lamp;
    lamp_word[16 +: 3] = plc_out;
  end

  always_comb begin
    next_prdata = '0;
    unique case (paddr)
      OFF_CTRL:   next_prdata[CTRL_READY +: NUM_CH] = host_ready;
      OFF_CHSTAT: next_prdata = {23'h0, alt_sel, ch_run, fault, need_load, ch_enable};
      OFF_IRQST:  next_prdata[IRQ_W-1:0] = irq_stat;
      OFF_IRQMSK: next_prdata[IRQ_W-1:0] = irq_mask;
      OFF_SYS:    next_prdata[3:0] = {sw_pos[1], sw_pos[0]};
      OFF_RATE:   next_prdata = rate_usps;
      OFF_VOLUME: next_prdata = volume_ustep;
      OFF_LAMPS:  next_prdata = lamp_word;
      default:    next_prdata = '0;
    endcase
  end

  // Read data is captured at the end of the setup cycle so it leaves a flop
  // with no wait state; a status bit that sets during the access phase is
  // seen on the next read instead.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end else begin
      prdata <= '0;
    end
  end

endmodule
`default_nettype wire

//--- dv/pce_top_checker.sv
// Concurrent checks on the ports of the pump channel enable and status top
`timescale 1ns/1ps
`default_nettype none
module pce_top_checker
  import pce_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
  parameter int unsigned ACT_HOLD = ACT_HOLD_CYC
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire pce_sw_t           sw_pos    [NUM_CH],
  input wire pce_ch_in_t        ch_in     [NUM_CH],
  input wire logic              ser_rx,
  input wire logic              plc_trigger,
  input wire pce_lamp_t         lamp      [NUM_CH],
  input wire pce_ser_t          ser_lamp,
  input wire pce_plc_t          plc_out,
  input wire logic [NUM_CH-1:0] ch_run,
  input wire logic [NUM_CH-1:0] ch_enable
);
  logic any_flt;
  logic any_load;
  assign any_flt  = ch_in[0].lin_fault | ch_in[0].rot_fault | ch_in[1].lin_fault | ch_in[1].rot_fault;
  assign any_load = (ch_enable[0] & (ch_in[0].load_need | ch_in[0].loading))
                  | (ch_enable[1] & (ch_in[1].load_need | ch_in[1].loading));

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Inputs held still long enough for the registered outputs to settle
  sequence calm_flt;
    $stable(any_flt) [*4];
  endsequence
  sequence calm_load;
    $stable(any_load) [*4];
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Red lamps stay dark until the first edge after reset, hence the guard
  en_lamp_a: assert property (lamp[0].green_en == $past(ch_enable[0]))
    else $error("enabled lamp does not follow enable");
  dis_lamp_a: assert property ($past(presetn) |-> lamp[0].red_dis != $past(ch_enable[0]))
    else $error("disabled lamp does not oppose enable");
  run_lamps_a: assert property ($past(presetn) |-> lamp[0].green_act == $past(ch_in[0].running)
                                && lamp[0].red_idle != $past(ch_in[0].running))
    else $error("active or idle lamp wrong");
  load_lamp_a: assert property ($past(presetn) |-> lamp[0].yel_load == $past(ch_in[0].load_need | ch_in[0].loading))
    else $error("load lamp wrong");
  fault_lamp_a: assert property ($past(presetn) |-> lamp[0].red_fault == $past(ch_in[0].lin_fault | ch_in[0].rot_fault))
    else $error("fault lamp wrong");
  lock_off_a: assert property (sw_pos[0] == PCE_SW_LOCK |=> !ch_enable[0])
    else $error("locked channel still enabled");
  rx_lamp_a: assert property (ser_rx |-> ##2 ser_lamp.rx_data)
    else $error("receive lamp missed activity");
  sys_fault_a: assert property (calm_flt |-> plc_out.fault_n == !any_flt)
    else $error("system fault output wrong");
  load_out_a: assert property (calm_load |-> plc_out.load_ok == !any_load)
    else $error("load required output wrong");
  alt_run_a: assert property (!(&ch_run))
    else $error("both channels run at once");
  trig_stop_a: assert property (!plc_trigger [*2] |=> ch_run == '0)
    else $error("channel runs without trigger");
endmodule
`default_nettype wire

//--- dv/pce_panel_model.sv
// Operator panel model: three-position switch with a bouncing momentary press
`timescale 1ns/1ps
`default_nettype none
module pce_panel_model
  import pce_pkg::*;
#(
  parameter int HOLD = 8
) (
  input  wire logic              pclk,
  input  wire logic [NUM_CH-1:0] press_go,
  input  wire logic [NUM_CH-1:0] lock,
  output var  pce_sw_t           sw_pos [NUM_CH]
);
  int cnt [NUM_CH] = '{default: 0};

  always_ff @(posedge pclk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (press_go[i])
        cnt[i] <= HOLD + 3;
      else if (cnt[i] > 0)
        cnt[i] <= cnt[i] - 1;
    end
  end

  // A press contacts for one cycle, bounces open for one, then holds
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (lock[i])
        sw_pos[i] = PCE_SW_LOCK;
      else if (cnt[i] > 0 && cnt[i] != HOLD + 2)
        sw_pos[i] = PCE_SW_SELECT;
      else
        sw_pos[i] = PCE_SW_REMOTE;
    end
  end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the pump channel enable and status top
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pce_pkg::*;
  localparam int DB = 4;
  localparam int AH = 4;
  logic              pclk        = 1'b0;
  logic              presetn     = 1'b0;
  logic              psel        = 1'b0;
  logic              penable     = 1'b0;
  logic              pwrite      = 1'b0;
  logic [7:0]        paddr       = 8'h00;
  logic [31:0]       pwdata      = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  pce_sw_t           sw_pos      [NUM_CH];
  pce_ch_in_t        ch_in       [NUM_CH] = '{default: '0};
  logic [3:0]        ser_in      = 4'h0;
  logic              plc_trigger = 1'b0;
  logic [NUM_CH-1:0] stroke_done = 2'h0;
  logic [NUM_CH-1:0] press_go    = 2'h0;
  logic [NUM_CH-1:0] lock        = 2'h0;
  pce_lamp_t         lamp        [NUM_CH];
  pce_ser_t          ser_lamp;
  pce_plc_t          plc_out;
  logic [NUM_CH-1:0] ch_run;
  logic [NUM_CH-1:0] ch_enable;
  logic [31:0]       rate_usps;
  logic [31:0]       volume_ustep;
  logic              irq;
  int                error_cnt   = 0;
  int                cmp_count   = 0;

  always #10 pclk = ~pclk;

  pce_panel_model #(.HOLD(8)) panel_u (.pclk(pclk), .press_go(press_go), .lock(lock), .sw_pos(sw_pos));

  pce_top #(.DEBOUNCE(DB), .ACT_HOLD(AH)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_pos(sw_pos), .ch_in(ch_in), .ser_rx(ser_in[3]), .ser_tx(ser_in[2]),
    .ser_rx_ctl(ser_in[1]), .ser_tx_ctl(ser_in[0]), .plc_trigger(plc_trigger),
    .stroke_done(stroke_done), .lamp(lamp), .ser_lamp(ser_lamp), .plc_out(plc_out),
    .ch_run(ch_run), .ch_enable(ch_enable), .rate_usps(rate_usps),
    .volume_ustep(volume_ustep), .irq(irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Called just after a rising edge; leaves one idle edge before returning
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end else begin
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic press(input logic [NUM_CH-1:0] m);
    press_go <= m;
    @(posedge pclk);
    press_go <= 2'h0;
    cyc(24);
  endtask

  function automatic logic [31:0] exp_lamp(input logic en, input pce_ch_in_t c);
    pce_lamp_t l;
    l = '{en, !en, c.running, !c.running, c.load_need | c.loading, c.lin_fault | c.rot_fault};
    return {26'h0, l};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        e;
    pce_ch_in_t  c;
    cyc(16);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_IRQMSK, 32'h0);
    rd(OFF_CHSTAT, 32'h0);
    chk(32'(lamp[0]), exp_lamp(1'b0, '0));
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(OFF_RATE, 32'hA5C3_0F01);
    wr(OFF_VOLUME, 32'h0001_2345);
    cyc(2);
    chk(rate_usps, 32'hA5C3_0F01);
    chk(volume_ustep, 32'h0001_2345);
    rd(OFF_RATE, 32'hA5C3_0F01);
    wr(OFF_CTRL, 32'h01);
    cyc(2);
    rd(OFF_CHSTAT, 32'h1);
    chk(32'(lamp[0]), exp_lamp(1'b1, '0));
    wr(OFF_CTRL, 32'h04);
    cyc(2);
    chk(32'(ch_enable), 32'h0);
    press(2'b10);
    chk(32'(ch_enable), 32'h2);
    rd(OFF_IRQST, 32'h20);
    wr(OFF_IRQST, 32'h20);
    press(2'b10);
    chk(32'(ch_enable), 32'h0);
    wr(OFF_IRQST, 32'h20);
    wr(OFF_CTRL, 32'h01);
    lock <= 2'b01;
    cyc(3);
    chk(32'(ch_enable), 32'h0);
    rd(OFF_SYS, 32'h2);
    wr(OFF_IRQMSK, 32'h01);
    wr(OFF_CTRL, 32'h01);
    cyc(2);
    chk(32'(ch_enable), 32'h0);
    rd(OFF_IRQST, 32'h01);
    chk(32'(irq), 32'h1);
    wr(OFF_IRQMSK, 32'h00);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(OFF_IRQMSK, 32'h01);
    wr(OFF_IRQST, 32'h01);
    cyc(2);
    chk(32'(irq), 32'h0);
    lock <= 2'b00;
    wr(OFF_CTRL, 32'h01);
    for (int b = 0; b < 5; b++) begin
      c = 5'b1 << b;
      ch_in[0] <= c;
      cyc(4);
      chk(32'(lamp[0]), exp_lamp(1'b1, c));
      chk(32'(plc_out), {29'h0, 1'b0, !(c.lin_fault | c.rot_fault), !(c.load_need | c.loading)});
    end
    rd(OFF_IRQST, 32'h04);
    ch_in[0] <= '0;
    ch_in[1] <= 5'b01000;
    cyc(4);
    chk(32'(plc_out), 32'h3);
    ch_in[1] <= '0;
    wr(OFF_CTRL, 32'h10);
    cyc(3);
    chk(32'(plc_out.ready), 32'h0);
    wr(OFF_CTRL, 32'h30);
    cyc(3);
    chk(32'(plc_out.ready), 32'h1);
    for (int i = 0; i < 4; i++) begin
      ser_in <= 4'(1 << i);
      @(posedge pclk);
      ser_in <= 4'h0;
      cyc(2);
      chk(32'(ser_lamp), 32'(1 << i));
      cyc(AH + 4);
      chk(32'(ser_lamp), 32'h0);
    end
    wr(OFF_CTRL, 32'h32);
    plc_trigger <= 1'b1;
    cyc(3);
    chk(32'(ch_run), 32'h1);
    stroke_done <= 2'b01;
    @(posedge pclk);
    stroke_done <= 2'b00;
    cyc(3);
    chk(32'(ch_run), 32'h2);
    plc_trigger <= 1'b0;
    cyc(3);
    chk(32'(ch_run), 32'h0);
    rd(OFF_LAMPS, 32'h0007_0924);
    tally_and_finish();
  end
endmodule

bind pce_top pce_top_checker #(.DEBOUNCE(DEBOUNCE), .ACT_HOLD(ACT_HOLD)) chk_u (
  .pclk(pclk), .presetn(presetn), .sw_pos(sw_pos), .ch_in(ch_in), .ser_rx(ser_rx),
  .plc_trigger(plc_trigger), .lamp(lamp), .ser_lamp(ser_lamp), .plc_out(plc_out),
  .ch_run(ch_run), .ch_enable(ch_enable));
`default_nettype wire
